// ### logic/luic_pkg.sv
// constants for the line unit interrupt control block
package luic_pkg;
	localparam logic [7:0] LUIC_MASK_PRI_ADDR = 8'h14;
	localparam logic [7:0] LUIC_MASK_SEC_ADDR = 8'h15;
	localparam logic [7:0] LUIC_EDGE_SEL_ADDR = 8'h16;
	localparam logic [7:0] LUIC_STATUS_ADDR = 8'h17;
	localparam logic [7:0] LUIC_PEND_PRI_ADDR = 8'h18;
	localparam logic [7:0] LUIC_PEND_SEC_ADDR = 8'h19;
	localparam logic [7:0] LUIC_MASK_PRI_RST = 8'hFF;
	localparam logic [7:0] LUIC_MASK_SEC_RST = 8'hFF;
	localparam logic [7:0] LUIC_EDGE_SEL_RST = 8'h00;
	localparam logic [6:0] LUIC_EDGE_SEL_USED = 7'h7F;
	// primary bit positions, shared by mask, edge select, status, pending
	localparam int LUIC_LOOP_ACT_BIT = 6;
	localparam int LUIC_LOOP_DEACT_BIT = 5;
	localparam int LUIC_PAT_SYNC_BIT = 4;
	localparam int LUIC_TX_CLK_BIT = 3;
	localparam int LUIC_DRV_FAIL_BIT = 2;
	localparam int LUIC_ALARM_BIT = 1;
	localparam int LUIC_SIG_LOSS_BIT = 0;
	localparam int LUIC_RSVD_BIT = 7;
	// secondary bit positions
	localparam int LUIC_DAC_OV_BIT = 7;
	localparam int LUIC_JIT_OV_BIT = 6;
	localparam int LUIC_JIT_UD_BIT = 5;
	localparam int LUIC_PAT_ERR_BIT = 4;
	localparam int LUIC_EXZ_BIT = 3;
	localparam int LUIC_CV_BIT = 2;
	localparam int LUIC_TIMER_BIT = 1;
	localparam int LUIC_CNT_OV_BIT = 0;
	// tx clock loss: no toggle for more than this many master cycles
	localparam int LUIC_TX_CLK_LOSS_CYC = 70;
endpackage : luic_pkg

// ### logic/luic_top.sv
// interrupt mask, edge select and pending logic of the line unit
`timescale 1ns/1ns

module luic_top
	import luic_pkg::*;
#(
	parameter int LOSS_CYC = LUIC_TX_CLK_LOSS_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_tx_line_clock,
	input wire logic i_loop_activate_status,
	input wire logic i_loop_deactivate_status,
	input wire logic i_pattern_sync_status,
	input wire logic i_driver_failure_status,
	input wire logic i_alarm_indication_status,
	input wire logic i_signal_loss_status,
	input wire logic [7:0] i_sec_event,
	output logic o_tx_clock_missing_status,
	output logic o_irq
);

	// idle counter is 8 bits and must be able to reach the limit
	if (LOSS_CYC < 1 || LOSS_CYC > 254) begin : g_bad_loss
		$error("LOSS_CYC out of range");
	end

	localparam logic [7:0] LOSS_LIM = 8'(LOSS_CYC);

	typedef struct packed {
		logic [7:0] mask_pri;
		logic [7:0] mask_sec;
		logic [6:0] edge_sel;
		logic [6:0] stat_prev;
		logic [6:0] pend_pri;
		logic [7:0] pend_sec;
		logic tx_line_clock_prev;
		logic [7:0] idle_cnt;
		logic tx_line_clock_lost;
		logic [7:0] rdata;
		logic irq;
	} luic_state_t;

	luic_state_t st_q;
	luic_state_t st_d;
	logic [6:0] stat_now;
	logic [6:0] pri_evt;

	// qualify a status change by its edge select
	function automatic logic [6:0] luic_edge(input logic [6:0] now,
		input logic [6:0] prev, input logic [6:0] both);
		luic_edge = (now & ~prev) | (both & (now ^ prev));
	endfunction : luic_edge

	// register map decode, used by the unmapped read check below
	function automatic logic luic_mapped(input logic [7:0] a);
		if (a == LUIC_MASK_PRI_ADDR || a == LUIC_MASK_SEC_ADDR) begin
			luic_mapped = 1'b1;
		end else if (a == LUIC_EDGE_SEL_ADDR || a == LUIC_STATUS_ADDR) begin
			luic_mapped = 1'b1;
		end else if (a == LUIC_PEND_PRI_ADDR) begin
			luic_mapped = 1'b1;
		end else if (a == LUIC_PEND_SEC_ADDR) begin
			luic_mapped = 1'b1;
		end else begin
			luic_mapped = 1'b0;
		end
	endfunction : luic_mapped

	always_comb begin
		stat_now = 7'h00;
		stat_now[LUIC_LOOP_ACT_BIT] = i_loop_activate_status;
		stat_now[LUIC_LOOP_DEACT_BIT] = i_loop_deactivate_status;
		stat_now[LUIC_PAT_SYNC_BIT] = i_pattern_sync_status;
		stat_now[LUIC_TX_CLK_BIT] = st_q.tx_line_clock_lost;
		stat_now[LUIC_DRV_FAIL_BIT] = i_driver_failure_status;
		stat_now[LUIC_ALARM_BIT] = i_alarm_indication_status;
		stat_now[LUIC_SIG_LOSS_BIT] = i_signal_loss_status;
		// rising only, or both edges when selected
		pri_evt = luic_edge(stat_now, st_q.stat_prev, st_q.edge_sel);
	end

	always_comb begin
		st_d = st_q;
		st_d.rdata = 8'h00;
		st_d.tx_line_clock_prev = i_tx_line_clock;
		st_d.stat_prev = stat_now;
		// idle counter restarts on every toggle of the line clock
		if (i_tx_line_clock != st_q.tx_line_clock_prev) begin
			st_d.idle_cnt = 8'h00;
			st_d.tx_line_clock_lost = 1'b0;
		end else if (st_q.idle_cnt < LOSS_LIM) begin
			st_d.idle_cnt = st_q.idle_cnt + 8'h01;
		end else begin
			st_d.tx_line_clock_lost = 1'b1;
		end
		// pending bits: write 1 to clear, a new event wins over the clear
		if (i_wr) begin
			if (i_addr == LUIC_MASK_PRI_ADDR) begin
				// reserved bit 7 stays 1
				st_d.mask_pri = {1'b1, i_wdata[6:0]};
			end else if (i_addr == LUIC_MASK_SEC_ADDR) begin
				st_d.mask_sec = i_wdata;
			end else if (i_addr == LUIC_EDGE_SEL_ADDR) begin
				st_d.edge_sel = i_wdata[6:0] & LUIC_EDGE_SEL_USED;
			end else if (i_addr == LUIC_PEND_PRI_ADDR) begin
				st_d.pend_pri = st_q.pend_pri & ~i_wdata[6:0];
			end else if (i_addr == LUIC_PEND_SEC_ADDR) begin
				st_d.pend_sec = st_q.pend_sec & ~i_wdata;
			end
		end
		// a 0 in a mask bit lets the event through
		st_d.pend_pri = st_d.pend_pri | (pri_evt & ~st_q.mask_pri[6:0]);
		// secondary sources arrive as one-cycle pulses
		st_d.pend_sec = st_d.pend_sec | (i_sec_event & ~st_q.mask_sec);
		st_d.irq = (|st_d.pend_pri) | (|st_d.pend_sec);
		if (i_rd) begin
			if (i_addr == LUIC_MASK_PRI_ADDR) begin
				st_d.rdata = st_q.mask_pri;
			end else if (i_addr == LUIC_MASK_SEC_ADDR) begin
				st_d.rdata = st_q.mask_sec;
			end else if (i_addr == LUIC_EDGE_SEL_ADDR) begin
				st_d.rdata = {1'b0, st_q.edge_sel};
			end else if (i_addr == LUIC_STATUS_ADDR) begin
				st_d.rdata = {1'b0, stat_now};
			end else if (i_addr == LUIC_PEND_PRI_ADDR) begin
				st_d.rdata = {1'b0, st_q.pend_pri};
			end else if (i_addr == LUIC_PEND_SEC_ADDR) begin
				st_d.rdata = st_q.pend_sec;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_q <= '0;
			st_q.mask_pri <= LUIC_MASK_PRI_RST;
			st_q.mask_sec <= LUIC_MASK_SEC_RST;
			st_q.edge_sel <= LUIC_EDGE_SEL_RST[6:0];
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_irq = st_q.irq;
	assign o_tx_clock_missing_status = st_q.tx_line_clock_lost;

	// assertion helpers: last cycle's events and masks, so the checks can
	// tell what the pending bits saw when they were loaded
	// no reset needed, every check is disabled while reset is low
	logic [7:0] sec_evt_q;
	logic [6:0] pri_evt_q;
	logic [7:0] mask_sec_q;
	logic [6:0] mask_pri_q;
	always_ff @(posedge i_clk) begin
		sec_evt_q <= i_sec_event;
		pri_evt_q <= pri_evt;
		mask_sec_q <= st_q.mask_sec;
		mask_pri_q <= st_q.mask_pri[6:0];
	end

	// unmasked secondary events of this cycle
	function automatic logic [7:0] sec_evt_mask();
		sec_evt_mask = i_sec_event & ~st_q.mask_sec;
	endfunction : sec_evt_mask

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_quiet_clk;
		$stable(i_tx_line_clock) [*8];
	endsequence

	mask_reserved_a: assert property (st_q.mask_pri[7])
		else $error("reserved mask bit not one");
	pri_pend_set_a: assert property ((|(pri_evt & ~st_q.mask_pri[6:0]))
		|=> (|st_q.pend_pri) && o_irq)
		else $error("unmasked primary event not pending");
	sec_pend_set_a: assert property ((|(i_sec_event & ~st_q.mask_sec))
		|=> o_irq)
		else $error("unmasked secondary event lost");
	sec_masked_a: assert property (((i_sec_event & st_q.mask_sec) != 8'h00
		&& (i_sec_event & ~st_q.mask_sec) == 8'h00 && !o_irq
		&& st_q.pend_pri == 7'h00 && st_q.pend_sec == 8'h00)
		|=> !o_irq)
		else $error("masked secondary event raised interrupt");
	fall_rising_a: assert property (($fell(i_signal_loss_status)
		&& !st_q.edge_sel[LUIC_SIG_LOSS_BIT]) |-> !pri_evt[LUIC_SIG_LOSS_BIT])
		else $error("falling edge raised event in rising mode");
	fall_both_a: assert property (($fell(i_alarm_indication_status)
		&& st_q.edge_sel[LUIC_ALARM_BIT]) |-> pri_evt[LUIC_ALARM_BIT])
		else $error("falling edge missed in both-edge mode");
	clk_loss_a: assert property ((i_tx_line_clock == st_q.tx_line_clock_prev
		&& st_q.idle_cnt >= LOSS_LIM) |=> o_tx_clock_missing_status)
		else $error("tx clock loss not flagged at limit");
	quiet_toggle_a: assert property (s_quiet_clk ##1
		$changed(i_tx_line_clock) |=> !o_tx_clock_missing_status)
		else $error("loss status kept after a toggle");
	loss_time_a: assert property ($rose(o_tx_clock_missing_status)
		|-> $past(st_q.idle_cnt) == LOSS_LIM)
		else $error("tx clock loss flagged early");
	idle_bound_a: assert property (st_q.idle_cnt <= LOSS_LIM)
		else $error("idle counter beyond limit");
	clk_back_a: assert property ($changed(i_tx_line_clock)
		|=> !o_tx_clock_missing_status)
		else $error("loss status not cleared on toggle");
	irq_level_a: assert property (o_irq == ((|st_q.pend_pri)
		|| (|st_q.pend_sec)))
		else $error("interrupt not tied to pending bits");

	// state seen at the first edge after reset is released
	reset_val_a: assert property ($past(!i_resetn) |->
		st_q.mask_pri == LUIC_MASK_PRI_RST && st_q.mask_sec == LUIC_MASK_SEC_RST
		&& st_q.edge_sel == LUIC_EDGE_SEL_RST[6:0] && !o_irq
		&& o_rdata == 8'h00 && !o_tx_clock_missing_status)
		else $error("wrong state after reset");

	// read data stand for one cycle only, unmapped reads return zero
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
	rd_unmapped_a: assert property (i_rd && !luic_mapped(i_addr)
		|=> o_rdata == 8'h00)
		else $error("unmapped read not zero");

	// writes land one cycle after the strobe
	wr_mask_pri_a: assert property (i_wr && i_addr == LUIC_MASK_PRI_ADDR
		|=> st_q.mask_pri == {1'b1, $past(i_wdata[6:0])})
		else $error("primary mask write lost");
	wr_mask_sec_a: assert property (i_wr && i_addr == LUIC_MASK_SEC_ADDR
		|=> st_q.mask_sec == $past(i_wdata))
		else $error("secondary mask write lost");
	wr_edge_a: assert property (i_wr && i_addr == LUIC_EDGE_SEL_ADDR
		|=> st_q.edge_sel == $past(i_wdata[6:0]))
		else $error("edge select write lost");

	// read back of every register
	rd_mask_pri_a: assert property (i_rd && i_addr == LUIC_MASK_PRI_ADDR
		|=> o_rdata == $past(st_q.mask_pri))
		else $error("primary mask read wrong");
	rd_mask_sec_a: assert property (i_rd && i_addr == LUIC_MASK_SEC_ADDR
		|=> o_rdata == $past(st_q.mask_sec))
		else $error("secondary mask read wrong");
	rd_edge_a: assert property (i_rd && i_addr == LUIC_EDGE_SEL_ADDR
		|=> o_rdata == {1'b0, $past(st_q.edge_sel)})
		else $error("edge select read wrong");
	rd_status_a: assert property (i_rd && i_addr == LUIC_STATUS_ADDR
		|=> o_rdata == {1'b0, $past(stat_now)})
		else $error("status read wrong");
	rd_pend_pri_a: assert property (i_rd && i_addr == LUIC_PEND_PRI_ADDR
		|=> o_rdata == {1'b0, $past(st_q.pend_pri)})
		else $error("primary pending read wrong");
	rd_pend_sec_a: assert property (i_rd && i_addr == LUIC_PEND_SEC_ADDR
		|=> o_rdata == $past(st_q.pend_sec))
		else $error("secondary pending read wrong");

	// write 1 clears; a secondary event in the same cycle must survive the clear
	clr_sec_a: assert property (i_wr && i_addr == LUIC_PEND_SEC_ADDR
		&& i_sec_event == 8'h00
		|=> (st_q.pend_sec & $past(i_wdata)) == 8'h00)
		else $error("secondary pending not cleared");
	clr_pri_a: assert property (i_wr && i_addr == LUIC_PEND_PRI_ADDR
		&& pri_evt == 7'h00
		|=> (st_q.pend_pri & $past(i_wdata[6:0])) == 7'h00)
		else $error("primary pending not cleared");
	set_wins_a: assert property (i_wr && i_addr == LUIC_PEND_SEC_ADDR
		&& (i_sec_event & ~st_q.mask_sec) != 8'h00
		|=> (st_q.pend_sec & $past(i_sec_event & ~st_q.mask_sec))
		== $past(i_sec_event & ~st_q.mask_sec))
		else $error("event lost in clear cycle");

	// a pending bit never appears without an unmasked event behind it
	sec_no_ghost_a: assert property ((st_q.pend_sec
		& ~$past(st_q.pend_sec)) != 8'h00 |-> $past(sec_evt_mask()) != 8'h00)
		else $error("secondary pending set without event");
	pri_no_ghost_a: assert property ((st_q.pend_pri
		& ~$past(st_q.pend_pri)) != 7'h00
		|-> $past(pri_evt & ~st_q.mask_pri[6:0]) != 7'h00)
		else $error("primary pending set without event");

	// per-source checks, the loop index is the bit position
	// edge and mask
	for (genvar i = 0; i < 7; i++) begin : g_pri_chk
		rise_evt_a: assert property (
			$rose(stat_now[i]) |-> pri_evt[i])
			else $error("rising status edge gave no event");
		fell_rise_a: assert property (
			$fell(stat_now[i]) && !st_q.edge_sel[i] |-> !pri_evt[i])
			else $error("falling edge counted in rising mode");
		fell_both_a: assert property (
			$fell(stat_now[i]) && st_q.edge_sel[i] && $past(i_resetn)
			|-> pri_evt[i])
			else $error("falling edge missed in both mode");
		pri_en_a: assert property (
			pri_evt_q[i] && !mask_pri_q[i] |-> st_q.pend_pri[i])
			else $error("enabled primary event not latched");
		pri_mask_a: assert property (
			pri_evt_q[i] && mask_pri_q[i] && !$past(st_q.pend_pri[i])
			|-> !st_q.pend_pri[i])
			else $error("masked primary event latched");
	end

	for (genvar i = 0; i < 8; i++) begin : g_sec_chk
		sec_en_a: assert property (
			sec_evt_q[i] && !mask_sec_q[i] |-> st_q.pend_sec[i])
			else $error("enabled secondary event not latched");
		sec_mask_a: assert property (
			sec_evt_q[i] && mask_sec_q[i] && !$past(st_q.pend_sec[i])
			|-> !st_q.pend_sec[i])
			else $error("masked secondary event latched");
	end

endmodule : luic_top

// ### test/tb.sv
// self-checking bench for the line unit interrupt control block
`timescale 1ns/1ns
module tb;
	import luic_pkg::*;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic txc = 1'b0;
	logic tx_run = 1'b1;
	logic [6:0] st = 7'h00;
	logic [7:0] i_sec_event = 8'h00;
	logic o_miss;
	logic o_irq;
	int err_count = 0;
	int compares = 0;
	int bits [6] = '{6, 5, 4, 2, 1, 0};
	// small loss count keeps the run short
	luic_top #(.LOSS_CYC(8)) u_luic_top (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_tx_line_clock(txc),
		.i_loop_activate_status(st[6]), .i_loop_deactivate_status(st[5]),
		.i_pattern_sync_status(st[4]), .i_driver_failure_status(st[2]),
		.i_alarm_indication_status(st[1]), .i_signal_loss_status(st[0]),
		.i_sec_event(i_sec_event), .o_tx_clock_missing_status(o_miss),
		.o_irq(o_irq));
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (tx_run) txc <= ~txc;
	end
	task automatic end_of_test;
		if (err_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1; i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", o_rdata, e);
	endtask : rd
	task automatic irq_is(input logic e);
		tick(3);
		chk("irq", {7'h00, o_irq}, {7'h00, e});
	endtask : irq_is
	task automatic reg_test;
		rd(LUIC_MASK_PRI_ADDR, 8'hFF);
		rd(LUIC_MASK_SEC_ADDR, 8'hFF);
		rd(LUIC_EDGE_SEL_ADDR, 8'h00);
		rd(8'h30, 8'h00);
		wr(LUIC_MASK_PRI_ADDR, 8'h00);
		rd(LUIC_MASK_PRI_ADDR, 8'h80);
		wr(LUIC_MASK_PRI_ADDR, 8'hFF);
		wr(LUIC_EDGE_SEL_ADDR, 8'hFF);
		rd(LUIC_EDGE_SEL_ADDR, 8'h7F);
		wr(LUIC_EDGE_SEL_ADDR, 8'h00);
	endtask : reg_test
	task automatic sec_pulse;
		@(posedge i_clk);
		i_sec_event <= 8'hFF;
		@(posedge i_clk);
		i_sec_event <= 8'h00;
	endtask : sec_pulse
	task automatic sec_test;
		sec_pulse();
		irq_is(1'b0);
		for (int i = 0; i < 8; i++) begin
			wr(LUIC_MASK_SEC_ADDR, ~(8'h01 << i));
			sec_pulse();
			irq_is(1'b1);
			rd(LUIC_PEND_SEC_ADDR, 8'h01 << i);
			wr(LUIC_PEND_SEC_ADDR, 8'hFF);
			irq_is(1'b0);
		end
		wr(LUIC_MASK_SEC_ADDR, 8'hFF);
	endtask : sec_test
	task automatic set_st(input int b, input logic v);
		@(posedge i_clk);
		st[b] <= v;
	endtask : set_st
	task automatic pri_test;
		logic [7:0] m;
		foreach (bits[k]) begin
			m = 8'h01 << bits[k];
			wr(LUIC_MASK_PRI_ADDR, ~m);
			set_st(bits[k], 1'b1);
			irq_is(1'b1);
			rd(LUIC_PEND_PRI_ADDR, m);
			wr(LUIC_PEND_PRI_ADDR, 8'hFF);
			set_st(bits[k], 1'b0);
			irq_is(1'b0);
			wr(LUIC_EDGE_SEL_ADDR, m);
			set_st(bits[k], 1'b1);
			irq_is(1'b1);
			wr(LUIC_PEND_PRI_ADDR, 8'hFF);
			set_st(bits[k], 1'b0);
			irq_is(1'b1);
			wr(LUIC_PEND_PRI_ADDR, 8'hFF);
			wr(LUIC_EDGE_SEL_ADDR, 8'h00);
			wr(LUIC_MASK_PRI_ADDR, 8'hFF);
		end
	endtask : pri_test
	task automatic reset_test;
		wr(LUIC_MASK_SEC_ADDR, 8'hFE);
		wr(LUIC_EDGE_SEL_ADDR, 8'h15);
		sec_pulse();
		irq_is(1'b1);
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		#1 chk("irq after reset", {7'h00, o_irq}, 8'h00);
		rd(LUIC_MASK_SEC_ADDR, 8'hFF);
		rd(LUIC_EDGE_SEL_ADDR, 8'h00);
		rd(LUIC_PEND_SEC_ADDR, 8'h00);
	endtask : reset_test
	task automatic tx_test;
		int n;
		wr(LUIC_MASK_PRI_ADDR, 8'hF7);
		tx_run <= 1'b0;
		// the held line clock must be seen as lost within a bounded time
		for (n = 0; n < 200 && o_miss !== 1'b1; n++) @(posedge i_clk);
		if (n == 200) begin
			err_count++;
			end_of_test();
		end
		chk("loss time", (n > 8) ? 8'h01 : 8'h00, 8'h01);
		irq_is(1'b1);
		rd(LUIC_STATUS_ADDR, 8'h08);
		wr(LUIC_PEND_PRI_ADDR, 8'hFF);
		wr(LUIC_EDGE_SEL_ADDR, 8'h08);
		tx_run <= 1'b1;
		irq_is(1'b1);
		rd(LUIC_PEND_PRI_ADDR, 8'h08);
	endtask : tx_test
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		reg_test();
		sec_test();
		pri_test();
		reset_test();
		tx_test();
		end_of_test();
	end
endmodule : tb
